// ===== vfie_regs.svh
// How it works
// - Serve a level only if global enable, level mask, top priority and source enable allow.
// - New entries start only when the core reports the end of an instruction.
// - Entering the interrupt cycle clears the global enable bit first.
// - Interrupt return restores counter and flags and sets global enable again in the same cycle.
// - Vector entries live in the ROM area from address zero to 0x0f.
// - Vectored entry pushes counter low byte, counter high byte, then flags.
// - Then it reads vector high byte, low byte, and jumps to the joined address.
// - Each two-byte vector starts at an even address, high byte first.
// - Fast vector pointer is sixteen bits in two byte registers at 0xda and 0xdb.
// - Fast entry takes about six cycles, vectored entry about twenty-two.
// - Mode bits four to two pick the fast level, mode bit one enables it.
// - Any of the eight levels may be chosen for fast entry.
// - Fast entry swaps counter and pointer, shadows flags, sets the fast status bit.
// - Fast return swaps back, restores shadow flags and clears the fast status bit.
// - Fast entry works for hardware-cleared and software-cleared pending levels alike.
// - The fast enable bit gates fast entry; global enable gates it as well.
// - Hardware-cleared levels get an acknowledge on entry and a pending clear once served.
// - Request flags stay readable by polling while global enable is off.
`ifndef VFIE_REGS_SVH
`define VFIE_REGS_SVH
`define VFIE_FVP_HI_OFS 8'hda
`define VFIE_FVP_LO_OFS 8'hdb
`define VFIE_REQ_OFS 8'hdc
`define VFIE_MASK_OFS 8'hde
`define VFIE_MODE_OFS 8'hdf
`define VFIE_GIE_BIT 0
`define VFIE_FEN_BIT 1
`define VFIE_FSEL_LSB 2
`define VFIE_FSEL_MSB 4
`define VFIE_MODE_RST 8'h00
`define VFIE_MASK_RST 8'h00
`define VFIE_FVP_RST 16'h0000
`define VFIE_VEC_BASE 8'h00
`define VFIE_HW_CLEAR 8'h0f
`define VFIE_FAST_CYC 6
`define VFIE_VEC_CYC 22
`endif

// ===== vfie_pkg.sv
package vfie_pkg;
   typedef logic [2:0] vfie_level_t;
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ACK,
      ST_PUSH_PCL,
      ST_PUSH_PCH,
      ST_PUSH_FLG,
      ST_RD_VH,
      ST_RD_VL,
      ST_PAD,
      ST_FAST_SWAP,
      ST_FAST_WAIT,
      ST_RET_FLG,
      ST_RET_PCH,
      ST_RET_PCL,
      ST_RET_FAST,
      ST_RET_DONE
   } vfie_state_e;
endpackage

// ===== vfie_prio_pick.sv
`timescale 1ns/1ps
module vfie_prio_pick #(
   parameter int NUM_LEVELS = 8
) (
   input wire logic [NUM_LEVELS-1:0] req, // Eligible levels
   output logic any, // Some level eligible
   output vfie_pkg::vfie_level_t idx // Winning level, lowest number first
);
   // The index is three bits wide, so more than eight levels cannot be named
   if ((NUM_LEVELS < 1) || (NUM_LEVELS > 8))
   begin : g_chk
      $error("vfie_prio_pick serves one to eight levels");
   end
   // Level 0 wins; scan from the top so the lowest index is written last
   always_comb
   begin
      any = 1'b0;
      idx = 3'h0;
      for (int i = NUM_LEVELS - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            any = 1'b1;
            idx = vfie_pkg::vfie_level_t'(i);
         end
      end
   end
endmodule

// ===== vfie_entry.sv
`timescale 1ns/1ps
`include "vfie_regs.svh"
module vfie_entry #(
   parameter int NUM_LEVELS = 8,
   parameter logic [7:0] HW_CLEAR_MASK = `VFIE_HW_CLEAR,
   parameter logic [7:0] VEC_BASE = `VFIE_VEC_BASE
) (
   input wire logic clock, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic [7:0] reg_addr, // Register file address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [7:0] reg_rdata, // Read data, one cycle after strobe
   input wire logic global_int_on_instr, // Global enable instruction
   input wire logic global_int_off_instr, // Global disable instruction
   input wire logic interrupt_return_instr, // Interrupt return instruction
   input wire logic instr_done, // Current instruction completes
   input wire logic [15:0] pc_in, // Core program counter
   input wire logic [7:0] flags_in, // Core flags
   input wire logic [7:0] irq_req, // Level request lines
   input wire logic [7:0] src_en, // Source enables per level
   output logic [7:0] acknowledge_strobe, // Acknowledge pulse to source
   output logic [7:0] pend_clear, // Hardware pending clear pulse
   output logic core_hold, // Core stalled by sequencer
   output logic pc_load, // Load pc_out into the core
   output logic [15:0] pc_out, // New program counter
   output logic flags_load, // Load flags_out into the core
   output logic [7:0] flags_out, // New flags
   output logic fast_status, // Fast routine in progress
   output logic stack_push, // Stack push request
   output logic stack_pop, // Stack pop request
   output logic [7:0] stack_wdata, // Byte to push
   input wire logic [7:0] stack_rdata, // Popped byte, valid with mem_ack
   output logic rom_rd, // ROM read request
   output logic [7:0] rom_addr, // ROM byte address in vector area
   input wire logic [7:0] rom_rdata, // ROM byte, valid with mem_ack
   input wire logic mem_ack // Completes stack or ROM request
);
   if (NUM_LEVELS != 8)
   begin : g_chk
      $error("vfie_entry serves exactly eight levels");
   end

   logic rst_meta;
   logic rst_n;
   vfie_pkg::vfie_state_e state;
   logic gie;
   logic fast_en;
   vfie_pkg::vfie_level_t fast_sel;
   logic [7:0] level_mask_reg;
   logic [15:0] fast_vector_pointer;
   logic [7:0] shadow_flags;
   logic [15:0] pc_save;
   logic [7:0] flags_save;
   vfie_pkg::vfie_level_t serv_level;
   logic entry_fast;
   logic [4:0] cyc;
   logic [7:0] eligible;
   logic win_any;
   vfie_pkg::vfie_level_t win_idx;
   logic take_fast;
   logic mode_wr;

   function automatic logic [7:0] level_bit(input vfie_pkg::vfie_level_t lv);
      level_bit = 8'h01 << lv;
   endfunction

   // Reset release is synchronised; assertion stays asynchronous
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   assign eligible = irq_req & src_en & level_mask_reg & {8{gie}};
   assign take_fast = fast_en && (win_idx == fast_sel);
   assign mode_wr = reg_wr && (reg_addr == `VFIE_MODE_OFS);

   vfie_prio_pick #(
      .NUM_LEVELS(NUM_LEVELS)
   ) u_pick (
      .req(eligible),
      .any(win_any),
      .idx(win_idx)
   );

   // Mode bits: hardware entry and return override a same-cycle software write of global enable
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gie <= 1'(`VFIE_MODE_RST >> `VFIE_GIE_BIT);
         fast_en <= 1'b0;
         fast_sel <= 3'h0;
      end
      else
      begin
         if (mode_wr)
         begin
            gie <= reg_wdata[`VFIE_GIE_BIT];
            fast_en <= reg_wdata[`VFIE_FEN_BIT];
            fast_sel <= reg_wdata[`VFIE_FSEL_MSB:`VFIE_FSEL_LSB];
         end
         if (global_int_on_instr)
            gie <= 1'b1;
         if (global_int_off_instr)
            gie <= 1'b0;
         if (state == vfie_pkg::ST_ACK)
            gie <= 1'b0;
         if (state == vfie_pkg::ST_RET_DONE)
            gie <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         level_mask_reg <= `VFIE_MASK_RST;
      else if (reg_wr && (reg_addr == `VFIE_MASK_OFS))
         level_mask_reg <= reg_wdata;
   end

   // Pointer is shared by software writes and the hardware swaps
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         fast_vector_pointer <= `VFIE_FVP_RST;
      else if ((state == vfie_pkg::ST_FAST_SWAP) || (state == vfie_pkg::ST_RET_FAST))
         fast_vector_pointer <= pc_save;
      else if (reg_wr && (reg_addr == `VFIE_FVP_HI_OFS))
         fast_vector_pointer[15:8] <= reg_wdata;
      else if (reg_wr && (reg_addr == `VFIE_FVP_LO_OFS))
         fast_vector_pointer[7:0] <= reg_wdata;
   end

   // Raw requests are readable whatever the global enable says
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `VFIE_FVP_HI_OFS: reg_rdata <= fast_vector_pointer[15:8];
            `VFIE_FVP_LO_OFS: reg_rdata <= fast_vector_pointer[7:0];
            `VFIE_REQ_OFS: reg_rdata <= irq_req;
            `VFIE_MASK_OFS: reg_rdata <= level_mask_reg;
            `VFIE_MODE_OFS: reg_rdata <= {3'h0, fast_sel, fast_en, gie};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         cyc <= 5'h00;
      else if (state == vfie_pkg::ST_IDLE)
         cyc <= 5'h00;
      else if (cyc != 5'h1f)
         cyc <= cyc + 5'h01;
   end

   // Sequencer; memory requests stay up until mem_ack
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= vfie_pkg::ST_IDLE;
         core_hold <= 1'b0;
         pc_load <= 1'b0;
         pc_out <= 16'h0000;
         flags_load <= 1'b0;
         flags_out <= 8'h00;
         fast_status <= 1'b0;
         shadow_flags <= 8'h00;
         pc_save <= 16'h0000;
         flags_save <= 8'h00;
         serv_level <= 3'h0;
         entry_fast <= 1'b0;
         stack_push <= 1'b0;
         stack_pop <= 1'b0;
         stack_wdata <= 8'h00;
         rom_rd <= 1'b0;
         rom_addr <= 8'h00;
         acknowledge_strobe <= 8'h00;
         pend_clear <= 8'h00;
      end
      else
      begin
         pc_load <= 1'b0;
         flags_load <= 1'b0;
         acknowledge_strobe <= 8'h00;
         pend_clear <= 8'h00;
         case (state)
            vfie_pkg::ST_IDLE:
            begin
               if (interrupt_return_instr)
               begin
                  core_hold <= 1'b1;
                  pc_save <= pc_in;
                  if (fast_status)
                     state <= vfie_pkg::ST_RET_FAST;
                  else
                  begin
                     state <= vfie_pkg::ST_RET_FLG;
                     stack_pop <= 1'b1;
                  end
               end
               else if (instr_done && win_any)
               begin
                  core_hold <= 1'b1;
                  state <= vfie_pkg::ST_ACK;
                  serv_level <= win_idx;
                  entry_fast <= take_fast;
                  pc_save <= pc_in;
                  flags_save <= flags_in;
               end
            end
            vfie_pkg::ST_ACK:
            begin
               acknowledge_strobe <= level_bit(serv_level);
               if (entry_fast)
                  state <= vfie_pkg::ST_FAST_SWAP;
               else
               begin
                  state <= vfie_pkg::ST_PUSH_PCL;
                  stack_push <= 1'b1;
                  stack_wdata <= pc_save[7:0];
               end
            end
            vfie_pkg::ST_PUSH_PCL:
            begin
               if (mem_ack)
               begin
                  stack_wdata <= pc_save[15:8];
                  state <= vfie_pkg::ST_PUSH_PCH;
               end
            end
            vfie_pkg::ST_PUSH_PCH:
            begin
               if (mem_ack)
               begin
                  stack_wdata <= flags_save;
                  state <= vfie_pkg::ST_PUSH_FLG;
               end
            end
            vfie_pkg::ST_PUSH_FLG:
            begin
               if (mem_ack)
               begin
                  stack_push <= 1'b0;
                  rom_rd <= 1'b1;
                  rom_addr <= VEC_BASE | {4'h0, serv_level, 1'b0};
                  state <= vfie_pkg::ST_RD_VH;
               end
            end
            vfie_pkg::ST_RD_VH:
            begin
               if (mem_ack)
               begin
                  pc_out[15:8] <= rom_rdata;
                  rom_addr <= rom_addr | 8'h01;
                  state <= vfie_pkg::ST_RD_VL;
               end
            end
            vfie_pkg::ST_RD_VL:
            begin
               if (mem_ack)
               begin
                  pc_out[7:0] <= rom_rdata;
                  rom_rd <= 1'b0;
                  state <= vfie_pkg::ST_PAD;
               end
            end
            vfie_pkg::ST_PAD:
            begin
               // Padding keeps vectored entry at a fixed length on fast memory
               if (cyc >= 5'(`VFIE_VEC_CYC - 1))
               begin
                  pc_load <= 1'b1;
                  pend_clear <= level_bit(serv_level) & HW_CLEAR_MASK;
                  core_hold <= 1'b0;
                  state <= vfie_pkg::ST_IDLE;
               end
            end
            vfie_pkg::ST_FAST_SWAP:
            begin
               pc_out <= fast_vector_pointer;
               shadow_flags <= flags_save;
               fast_status <= 1'b1;
               state <= vfie_pkg::ST_FAST_WAIT;
            end
            vfie_pkg::ST_FAST_WAIT:
            begin
               if (cyc >= 5'(`VFIE_FAST_CYC - 1))
               begin
                  pc_load <= 1'b1;
                  pend_clear <= level_bit(serv_level) & HW_CLEAR_MASK;
                  core_hold <= 1'b0;
                  state <= vfie_pkg::ST_IDLE;
               end
            end
            vfie_pkg::ST_RET_FLG:
            begin
               if (mem_ack)
               begin
                  flags_out <= stack_rdata;
                  state <= vfie_pkg::ST_RET_PCH;
               end
            end
            vfie_pkg::ST_RET_PCH:
            begin
               if (mem_ack)
               begin
                  pc_out[15:8] <= stack_rdata;
                  state <= vfie_pkg::ST_RET_PCL;
               end
            end
            vfie_pkg::ST_RET_PCL:
            begin
               if (mem_ack)
               begin
                  pc_out[7:0] <= stack_rdata;
                  stack_pop <= 1'b0;
                  state <= vfie_pkg::ST_RET_DONE;
               end
            end
            vfie_pkg::ST_RET_FAST:
            begin
               pc_out <= fast_vector_pointer;
               flags_out <= shadow_flags;
               fast_status <= 1'b0;
               state <= vfie_pkg::ST_RET_DONE;
            end
            vfie_pkg::ST_RET_DONE:
            begin
               pc_load <= 1'b1;
               flags_load <= 1'b1;
               core_hold <= 1'b0;
               state <= vfie_pkg::ST_IDLE;
            end
            default:
            begin
               state <= vfie_pkg::ST_IDLE;
               core_hold <= 1'b0;
            end
         endcase
      end
   end

   gie_qualify_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_ACK) |-> $past(gie) && (($past(eligible) & level_bit(serv_level)) != 8'h00))
      else $error("entry taken without qualification");

   instr_boundary_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(state == vfie_pkg::ST_ACK) |-> $past(instr_done))
      else $error("entry taken mid instruction");

   gie_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_ACK) |=> !gie)
      else $error("global enable not cleared on entry");

   ret_gie_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_RET_DONE) |=> gie && pc_load && flags_load)
      else $error("return did not restore and re-enable");

   vector_even_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rom_rd && (state == vfie_pkg::ST_RD_VH)) |-> (rom_addr[0] == 1'b0) && (rom_addr[3:1] == serv_level))
      else $error("vector high byte not at even address");

   push_order_a: assert property (@(posedge clock) disable iff (!rst_n)
      ((state == vfie_pkg::ST_PUSH_PCL) && mem_ack) |=> (stack_wdata == pc_save[15:8]) ##0
      (state == vfie_pkg::ST_PUSH_PCH))
      else $error("stack push order wrong");

   fast_time_a: assert property (@(posedge clock) disable iff (!rst_n)
      (pc_load && entry_fast && fast_status && !flags_load) |-> ($past(cyc) == 5'(`VFIE_FAST_CYC - 1)))
      else $error("fast entry length wrong");

   vec_time_a: assert property (@(posedge clock) disable iff (!rst_n)
      (pc_load && !entry_fast && !flags_load) |-> ($past(cyc) >= 5'(`VFIE_VEC_CYC - 1)))
      else $error("vectored entry too short");

   fast_swap_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_FAST_SWAP) |=> (pc_out == $past(fast_vector_pointer)) && fast_status &&
      (fast_vector_pointer == $past(pc_save)) && (shadow_flags == $past(flags_save)))
      else $error("fast swap wrong");

   fast_ret_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_RET_FAST) |=> !fast_status && (flags_out == $past(shadow_flags)) ##1 flags_load)
      else $error("fast return wrong");

   fast_entry_c: cover property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_FAST_SWAP));
   vec_entry_c: cover property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_PAD) ##1 pc_load);
   fast_ret_c: cover property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_RET_FAST));
   vec_ret_c: cover property (@(posedge clock) disable iff (!rst_n)
      (state == vfie_pkg::ST_RET_PCL) && mem_ack);
endmodule

// ===== vfie_mem_model.sv
`timescale 1ns/1ps
module vfie_mem_model (
   input wire logic clock, // System clock
   input wire logic resetn, // Reset, active low
   input wire logic slow, // Stretch each answer
   input wire logic stack_push, // Push request
   input wire logic stack_pop, // Pop request
   input wire logic [7:0] stack_wdata, // Pushed byte
   output logic [7:0] stack_rdata, // Popped byte
   input wire logic rom_rd, // ROM read request
   input wire logic [7:0] rom_addr, // ROM address
   output logic [7:0] rom_rdata, // ROM byte
   output logic mem_ack // One byte done
);
   logic [7:0] stk [0:15];
   int sp;
   int wait_n;
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mem_ack <= 1'b0;
         sp <= 0;
         wait_n <= 0;
         stack_rdata <= 8'h00;
         rom_rdata <= 8'h00;
      end
      else if ((stack_push || stack_pop || rom_rd) && !mem_ack && wait_n == 0)
      begin
         mem_ack <= 1'b1;
         wait_n <= slow ? 3 : 0;
         if (stack_push)
         begin
            stk[sp] <= stack_wdata;
            sp <= sp + 1;
         end
         if (stack_pop)
         begin
            stack_rdata <= stk[sp-1];
            sp <= sp - 1;
         end
         // Distinct byte per address so a wrong fetch shows in the jump target
         rom_rdata <= rom_addr ^ 8'h5a;
      end
      else
      begin
         mem_ack <= 1'b0;
         if (wait_n > 0)
            wait_n <= wait_n - 1;
         // Stale data is inverted so nothing can lean on the last byte
         stack_rdata <= ~stack_rdata;
         rom_rdata <= ~rom_rdata;
      end
   end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "vfie_regs.svh"
module tb;
   logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, slow = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, flags_in = 0;
   logic global_int_on_instr = 0, global_int_off_instr = 0;
   logic interrupt_return_instr = 0, instr_done = 0;
   logic [15:0] pc_in = 0, pc_out;
   logic [7:0] irq_req = 0, src_en = 0, acknowledge_strobe, pend_clear, flags_out;
   logic core_hold, pc_load, flags_load, fast_status, stack_push, stack_pop;
   logic [7:0] stack_wdata, stack_rdata, rom_addr, rom_rdata, ack_cap, rv, hi;
   logic rom_rd, mem_ack;
   int n_mismatch = 0, checks_done = 0, cyc = 0, n, sp0;

   vfie_entry dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .global_int_on_instr, .global_int_off_instr, .interrupt_return_instr, .instr_done,
      .pc_in, .flags_in, .irq_req, .src_en, .acknowledge_strobe, .pend_clear, .core_hold,
      .pc_load, .pc_out, .flags_load, .flags_out, .fast_status, .stack_push, .stack_pop,
      .stack_wdata, .stack_rdata, .rom_rd, .rom_addr, .rom_rdata, .mem_ack);
   vfie_mem_model mdl (.clock, .resetn, .slow, .stack_push, .stack_pop, .stack_wdata,
      .stack_rdata, .rom_rd, .rom_addr, .rom_rdata, .mem_ack);

   initial forever #12.5 clock = ~clock;

   always @(negedge clock)
   begin
      cyc++;
      if (acknowledge_strobe !== 8'h00) ack_cap = acknowledge_strobe;
      if (cyc == 30000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clock);
      reg_wr = 0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1;
      @(negedge clock);
      reg_rd = 0;
      d = reg_rdata;
   endtask

   task automatic pulse(ref logic s);
      @(negedge clock);
      s = 1;
      @(negedge clock);
      s = 0;
   endtask

   // Pulses s, then counts cycles to the jump; 100 means nothing happened
   task automatic run(ref logic s, output int cnt);
      ack_cap = 0;
      pulse(s);
      cnt = 0;
      while (pc_load !== 1'b1 && cnt < 100)
      begin
         @(negedge clock);
         cnt++;
      end
   endtask

   task automatic t_regs;
      logic [7:0] a [5] = '{8'hda, 8'hdb, 8'hdd, 8'hde, 8'hdf};
      foreach (a[i])
      begin
         rd(a[i], rv);
         chk("reset value", rv, 0);
      end
      wr(`VFIE_FVP_HI_OFS, 8'h12);
      wr(`VFIE_FVP_LO_OFS, 8'h34);
      wr(8'hdd, 8'hff);
      rd(`VFIE_FVP_HI_OFS, hi);
      rd(`VFIE_FVP_LO_OFS, rv);
      chk("pointer", {hi, rv}, 16'h1234);
      rd(8'hdd, rv);
      chk("unmapped", rv, 0);
   endtask

   task automatic t_refuse;
      src_en = 8'hff;
      irq_req = 8'h40;
      wr(`VFIE_MASK_OFS, 8'hff);
      wr(`VFIE_MODE_OFS, 8'h1a);
      run(instr_done, n);
      chk("no entry gie off", n, 100);
      rd(`VFIE_REQ_OFS, rv);
      chk("poll flags", rv, 8'h40);
      wr(`VFIE_MODE_OFS, 8'h01);
      wr(`VFIE_MASK_OFS, 8'hbf);
      run(instr_done, n);
      chk("masked level", n, 100);
      wr(`VFIE_MASK_OFS, 8'hff);
      src_en = 8'hbf;
      run(instr_done, n);
      chk("source off", n, 100);
      wr(`VFIE_MODE_OFS, 8'h00);
      src_en = 8'hff;
   endtask

   task automatic t_vec(input int l, input logic s);
      slow = s;
      irq_req = 8'h80 | (8'h01 << l);
      pc_in = 16'h4c00 + 16'(l);
      flags_in = 8'ha0 + 8'(l);
      sp0 = mdl.sp;
      pulse(global_int_on_instr);
      repeat (5) @(negedge clock);
      chk("wait for instr end", core_hold, 0);
      run(instr_done, n);
      irq_req = 0;
      chk("vectored length", 16'(n >= 21 && n < 100), 1);
      chk("vector jump", pc_out, {8'(2*l) ^ 8'h5a, 8'(2*l+1) ^ 8'h5a});
      chk("push pc low", mdl.stk[sp0], pc_in[7:0]);
      chk("push pc high", mdl.stk[sp0+1], pc_in[15:8]);
      chk("push flags", mdl.stk[sp0+2], flags_in);
      chk("ack", ack_cap, 8'h01 << l);
      chk("pend clear", pend_clear, (8'h01 << l) & `VFIE_HW_CLEAR);
      rd(`VFIE_MODE_OFS, rv);
      chk("gie cleared", rv[0], 0);
      pc_in = 16'h0777;
      flags_in = 8'h11;
      run(interrupt_return_instr, n);
      chk("ret pc", pc_out, 16'h4c00 + 16'(l));
      chk("ret flags", flags_out, 8'ha0 + 8'(l));
      chk("flags load", flags_load, 1);
      rd(`VFIE_MODE_OFS, rv);
      chk("gie set", rv[0], 1);
      slow = 0;
   endtask

   task automatic t_fast(input int l);
      // Pointer, then level field, then enable; reload each time
      wr(`VFIE_FVP_HI_OFS, 8'h60);
      wr(`VFIE_FVP_LO_OFS, 8'(l*16));
      wr(`VFIE_MODE_OFS, 8'(l << 2));
      wr(`VFIE_MODE_OFS, 8'(l << 2) | 8'h02);
      irq_req = 8'h80 | (8'h01 << l);
      pc_in = 16'h2100 + 16'(l);
      flags_in = 8'h3c;
      pulse(global_int_off_instr);
      run(instr_done, n);
      chk("fast gated by gie", n, 100);
      pulse(global_int_on_instr);
      run(instr_done, n);
      irq_req = 0;
      chk("fast length", n, `VFIE_FAST_CYC);
      chk("fast jump", pc_out, 16'h6000 + 16'(l*16));
      chk("fast status", fast_status, 1);
      chk("fast ack", ack_cap, 8'h01 << l);
      chk("fast pend", pend_clear, (8'h01 << l) & `VFIE_HW_CLEAR);
      rd(`VFIE_FVP_HI_OFS, hi);
      rd(`VFIE_FVP_LO_OFS, rv);
      chk("pointer holds pc", {hi, rv}, 16'h2100 + 16'(l));
      rd(`VFIE_MODE_OFS, rv);
      chk("fast gie cleared", rv, 8'(l << 2) | 8'h02);
      pc_in = 16'h6abc;
      flags_in = 8'h00;
      run(interrupt_return_instr, n);
      chk("fast ret pc", pc_out, 16'h2100 + 16'(l));
      chk("shadow flags", flags_out, 8'h3c);
      chk("status off", fast_status, 0);
      rd(`VFIE_FVP_HI_OFS, hi);
      rd(`VFIE_FVP_LO_OFS, rv);
      chk("pointer swapped back", {hi, rv}, 16'h6abc);
      rd(`VFIE_MODE_OFS, rv);
      chk("fast gie set", rv[0], 1);
   endtask

   task automatic t_nest;
      // Level 6 is served; its routine narrows the mask so only levels 0 to 5 may nest
      irq_req = 8'h40;
      pc_in = 16'h5a00;
      pulse(global_int_on_instr);
      run(instr_done, n);
      rd(`VFIE_MASK_OFS, hi);
      wr(`VFIE_MASK_OFS, 8'h3f);
      irq_req = 8'h42;
      pulse(global_int_on_instr);
      pc_in = 16'h5b00;
      run(instr_done, n);
      chk("nested vector", pc_out, 16'h5859);
      run(interrupt_return_instr, n);
      chk("nested ret", pc_out, 16'h5b00);
      irq_req = 8'h00;
      wr(`VFIE_MASK_OFS, hi);
      run(interrupt_return_instr, n);
      chk("outer ret", pc_out, 16'h5a00);
   endtask

   task automatic wrap_up;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clock);
      @(negedge clock);
      resetn = 1;
      repeat (4) @(negedge clock);
      t_regs();
      t_refuse();
      t_vec(2, 0);
      t_vec(5, 1);
      // Every level in turn takes the fast path
      for (int l = 0; l < 8; l++)
         t_fast(l);
      t_nest();
      wrap_up();
   end
endmodule
